// ---- design/cantmf_top.sv ----
// Mode selection, dominant timeout, fault protection and wake detection
`timescale 1ns/100ps
`default_nettype none
module cantmf_top #(
  parameter int DOMTO_CYCLES = cantmf_pkg::DOMINANT_TIMEOUT_CYCLES,
  parameter int MODE_CYCLES = cantmf_pkg::MODE_DELAY_CYCLES,
  parameter int WFLT_CYCLES = cantmf_pkg::WAKE_FILTER_CYCLES,
  parameter int WTO_CYCLES  = cantmf_pkg::WAKE_TIMEOUT_CYCLES,
  parameter bit IO_SUPPLY_VARIANT = 1'b1
) (
  // Clock, reset, enable
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  input  wire logic clk_en_i,
  // Controller pins with pull-up sense
  input  wire logic txd_i,
  input  wire logic txd_float_i,
  input  wire logic standby_select_i,
  input  wire logic standby_select_float_i,
  // Supply and temperature monitors
  input  wire logic main_supply_undervoltage_i,
  input  wire logic io_supply_undervoltage_i,
  input  wire logic thermal_shutdown_i,
  // Bus receivers
  input  wire logic bus_dominant_i,
  input  wire logic lp_bus_dominant_i,
  // Receive output to the controller
  output logic      rxd_o,
  output logic      rxd_oe_o,
  output logic      rxd_valid_o,
  input  wire logic rxd_ready_i,
  // Bus analog control
  output logic      drv_dominant_o,
  output logic      drv_enable_o,
  output logic      bias_mid_o,
  output logic      bias_gnd_o,
  output logic      rx_main_en_o,
  output logic      rx_lp_en_o,
  // Status
  output cantmf_pkg::cantmf_mode_type mode_o,
  output logic      dominant_timeout_o,
  output logic      wake_seen_o
);
  import cantmf_pkg::*;

  typedef struct packed {
    cantmf_mode_type  mode;
    cantmf_wake_type  wake;
    logic             txd_prev;
    logic             domto_fault;
    logic [CNT_W-1:0] domto_cnt;
    logic [CNT_W-1:0] mode_cnt;
    logic [CNT_W-1:0] wto_cnt;
    logic             wake_low;
    logic             drv_dom;
    logic             drv_en;
    logic             bias_mid;
    logic             bias_gnd;
    logic             rx_main;
    logic             rx_lp;
    logic             rxd_val;
    logic             rxd_oe;
  } cantmf_top_type;

  cantmf_top_type s_q, s_d;

  logic txd_eff;
  logic sel_eff;
  logic any_uv;
  logic filt_dom;
  logic filt_rec;
  logic buf_in_ready;
  logic [1:0] buf_out;

  function automatic logic cnt_hit(input logic [CNT_W-1:0] c, input int lim);
    cnt_hit = (c >= CNT_W'(lim - 1));
  endfunction

  // Pull-ups: floating pins read as recessive and as standby
  assign txd_eff = txd_float_i ? LVL_REC : txd_i;
  assign sel_eff = standby_select_float_i ? 1'b1 : standby_select_i;
  assign any_uv  = main_supply_undervoltage_i || io_supply_undervoltage_i;

  cantmf_filter #(
    .FILTER_CYCLES (WFLT_CYCLES),
    .CNT_W         (CNT_W)
  ) u_filter (
    .ref_clk_i   (ref_clk_i),
    .rstn_i      (rstn_i),
    .clk_en_i    (clk_en_i),
    .enable_i    (s_q.mode == MODE_STANDBY),
    .bus_level_i (!lp_bus_dominant_i),
    .filt_dom_o  (filt_dom),
    .filt_rec_o  (filt_rec)
  );

  always_comb begin
    s_d          = s_q;
    s_d.txd_prev = txd_eff;

    // Mode selection, undervoltage ranked first
    if (any_uv) begin
      if (IO_SUPPLY_VARIANT && main_supply_undervoltage_i && !io_supply_undervoltage_i
          && sel_eff) begin
        s_d.mode = MODE_STANDBY;
      end else begin
        s_d.mode = MODE_PROTECT;
      end
      s_d.mode_cnt = CNT_ZERO;
    end else begin
      case (s_q.mode)
        MODE_PROTECT: begin
          s_d.mode     = MODE_DELAY;
          s_d.mode_cnt = CNT_ZERO;
        end
        MODE_DELAY: begin
          s_d.mode_cnt = s_q.mode_cnt + CNT_ONE;
          if (cnt_hit(s_q.mode_cnt, MODE_CYCLES)) begin
            s_d.mode = sel_eff ? MODE_STANDBY : MODE_NORMAL;
          end
        end
        MODE_NORMAL: begin
          if (sel_eff) begin
            s_d.mode = MODE_STANDBY;
          end
        end
        MODE_STANDBY: begin
          if (!sel_eff) begin
            s_d.mode     = MODE_DELAY;
            s_d.mode_cnt = CNT_ZERO;
          end
        end
        default: s_d.mode = MODE_PROTECT;
      endcase
    end

    // Dominant timeout, armed only in normal mode
    if (s_q.mode != MODE_NORMAL) begin
      s_d.domto_fault = 1'b0;
      s_d.domto_cnt   = CNT_ZERO;
    end else if (txd_eff == LVL_REC) begin
      s_d.domto_fault = 1'b0;
      s_d.domto_cnt   = CNT_ZERO;
    end else if (s_q.txd_prev == LVL_REC) begin
      s_d.domto_cnt = CNT_ONE;
    end else if (!s_q.domto_fault) begin
      s_d.domto_cnt = s_q.domto_cnt + CNT_ONE;
      if (cnt_hit(s_q.domto_cnt, DOMTO_CYCLES)) begin
        s_d.domto_fault = 1'b1;
      end
    end

    // Wake pattern monitor, active only in standby
    if (s_q.mode != MODE_STANDBY) begin
      s_d.wake     = WAKE_IDLE;
      s_d.wto_cnt  = CNT_ZERO;
      s_d.wake_low = 1'b0;
    end else begin
      case (s_q.wake)
        WAKE_IDLE: begin
          s_d.wto_cnt = CNT_ZERO;
          if (filt_dom) begin
            s_d.wake = WAKE_GOTDOM;
          end
        end
        WAKE_GOTDOM: begin
          s_d.wto_cnt = s_q.wto_cnt + CNT_ONE;
          if (cnt_hit(s_q.wto_cnt, WTO_CYCLES)) begin
            s_d.wake = WAKE_IDLE;
          end else if (filt_rec) begin
            s_d.wake = WAKE_GOTREC;
          end
        end
        WAKE_GOTREC: begin
          s_d.wto_cnt = s_q.wto_cnt + CNT_ONE;
          if (cnt_hit(s_q.wto_cnt, WTO_CYCLES)) begin
            s_d.wake = WAKE_IDLE;
          end else if (filt_dom) begin
            s_d.wake     = WAKE_DONE;
            s_d.wake_low = 1'b1;
          end
        end
        WAKE_DONE: begin
          // Each further filtered dominant pulls receive low until filtered recessive
          if (filt_dom) begin
            s_d.wake_low = 1'b1;
          end else if (filt_rec) begin
            s_d.wake_low = 1'b0;
          end
        end
        default: s_d.wake = WAKE_IDLE;
      endcase
    end

    // Pin and analog control derived from the next mode
    s_d.drv_en   = 1'b0;
    s_d.drv_dom  = 1'b0;
    s_d.bias_mid = 1'b0;
    s_d.bias_gnd = 1'b0;
    s_d.rx_main  = 1'b0;
    s_d.rx_lp    = 1'b0;
    s_d.rxd_val  = LVL_REC;
    s_d.rxd_oe   = 1'b0;
    case (s_d.mode)
      MODE_NORMAL: begin
        // Driver off on a timeout or over-temperature; receiver keeps working
        s_d.drv_en   = !s_d.domto_fault && !thermal_shutdown_i;
        s_d.drv_dom  = s_d.drv_en && (txd_eff == LVL_DOM);
        s_d.bias_mid = 1'b1;
        s_d.rx_main  = 1'b1;
        s_d.rxd_val  = bus_dominant_i ? LVL_DOM : LVL_REC;
        s_d.rxd_oe   = 1'b1;
      end
      MODE_STANDBY: begin
        s_d.bias_gnd = 1'b1;
        s_d.rx_lp    = 1'b1;
        s_d.rxd_val  = s_d.wake_low ? LVL_DOM : LVL_REC;
        s_d.rxd_oe   = 1'b1;
      end
      default: begin
        // Protected: bus released; receive held high only with I/O supply good
        s_d.rxd_oe = IO_SUPPLY_VARIANT && main_supply_undervoltage_i
                     && !io_supply_undervoltage_i;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '{mode: MODE_PROTECT, wake: WAKE_IDLE, txd_prev: 1'b1, domto_fault: 1'b0,
               domto_cnt: '0, mode_cnt: '0, wto_cnt: '0, wake_low: 1'b0, drv_dom: 1'b0,
               drv_en: 1'b0, bias_mid: 1'b0, bias_gnd: 1'b0, rx_main: 1'b0,
               rx_lp: 1'b0, rxd_val: 1'b1, rxd_oe: 1'b0};
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  // Receive level passes a two-entry buffer; a stalled reader keeps its head word, but new samples are dropped while it is full
  cantmf_buf #(
    .WIDTH (SAMPLE_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .ref_clk_i   (ref_clk_i),
    .rstn_i      (rstn_i),
    .clk_en_i    (clk_en_i),
    .in_valid_i  (1'b1),
    .in_ready_o  (buf_in_ready),
    .in_data_i   ({s_q.rxd_oe, s_q.rxd_val}),
    .out_valid_o (rxd_valid_o),
    .out_ready_i (rxd_ready_i),
    .out_data_o  (buf_out)
  );

  assign rxd_o              = buf_out[0];
  assign rxd_oe_o           = buf_out[1];
  assign drv_dominant_o     = s_q.drv_dom;
  assign drv_enable_o       = s_q.drv_en;
  assign bias_mid_o         = s_q.bias_mid;
  assign bias_gnd_o         = s_q.bias_gnd;
  assign rx_main_en_o       = s_q.rx_main;
  assign rx_lp_en_o         = s_q.rx_lp;
  assign mode_o             = s_q.mode;
  assign dominant_timeout_o = s_q.domto_fault;
  assign wake_seen_o        = (s_q.wake == WAKE_DONE) && !buf_in_ready;
endmodule
`default_nettype wire

// ---- inc/cantmf_pkg.sv ----
// Constants and types for the CAN transceiver mode and fault control block
// Functional notes
// - Dominant timeout supervision runs only in normal mode.
// - Each falling edge of transmit data starts the dominant timeout measurement.
// - No rising edge before the timeout period disables the bus driver.
// - Transmit data back high re-enables the driver and clears the timeout fault.
// - During timeout fault the receiver stays biased and receive output follows the bus.
// - Over-temperature turns off the driver and blocks transmit; restored when cleared.
// - During thermal shutdown the bus stays biased and receive path keeps working.
// - Undervoltage on the I/O supply forces protected state: bus and receive output released.
// - Main supply low, I/O good, standby high: standby, weak ground bias, wake signalling.
// - Main supply low, I/O good, standby low: protected, bus released, receive held high.
// - After undervoltage clears, wait the mode delay before returning to normal.
// - Floating transmit data defaults recessive through a weak pull-up.
// - Floating standby select defaults high, giving low-power standby.
// - Standby select low gives normal mode; high gives standby mode.
// - Standby disables the driver; receive output stays high until a valid wake pattern.
// - Low transmit drives the bus dominant; dominant bus reads as low receive output.
// - Wake pattern is dominant, recessive, dominant filtered; then every filtered dominant is low.
// - Wake pattern not complete within the wake timeout resets the bus monitor.
package cantmf_pkg;

  localparam int CLK_FREQ_MHZ = 100;
  // Durations in microseconds, converted to cycles at the clock rate
  localparam int DOMINANT_TIMEOUT_PERIOD_US = 1200;
  localparam int MODE_DELAY_US             = 20;
  localparam int WAKE_FILTER_US            = 1;
  localparam int WAKE_PATTERN_TIMEOUT_US   = 1800;
  localparam int DOMINANT_TIMEOUT_CYCLES   = DOMINANT_TIMEOUT_PERIOD_US * CLK_FREQ_MHZ;
  localparam int MODE_DELAY_CYCLES         = MODE_DELAY_US * CLK_FREQ_MHZ;
  localparam int WAKE_FILTER_CYCLES        = WAKE_FILTER_US * CLK_FREQ_MHZ;
  localparam int WAKE_TIMEOUT_CYCLES       = WAKE_PATTERN_TIMEOUT_US * CLK_FREQ_MHZ;
  localparam int CNT_W                     = 20;
  localparam int SAMPLE_W                  = 2;
  localparam int BUF_DEPTH                 = 2;

  localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 20'h00001;
  localparam logic             LVL_REC  = 1'b1;
  localparam logic             LVL_DOM  = 1'b0;

  typedef enum logic [3:0] {
    MODE_PROTECT = 4'h1,
    MODE_DELAY   = 4'h2,
    MODE_NORMAL  = 4'h4,
    MODE_STANDBY = 4'h8
  } cantmf_mode_type;

  typedef enum logic [3:0] {
    WAKE_IDLE   = 4'h1,
    WAKE_GOTDOM = 4'h2,
    WAKE_GOTREC = 4'h4,
    WAKE_DONE   = 4'h8
  } cantmf_wake_type;

endpackage

// ---- design/cantmf_filter.sv ----
// Bus level filter: reports a level once it has been stable for a filter time
`timescale 1ns/100ps
`default_nettype none
module cantmf_filter #(
  parameter int FILTER_CYCLES = 100,
  parameter int CNT_W         = 20
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  input  wire logic clk_en_i,
  // Monitor control
  input  wire logic enable_i,
  input  wire logic bus_level_i,
  // Filtered events
  output logic      filt_dom_o,
  output logic      filt_rec_o
);
  import cantmf_pkg::*;

  typedef struct packed {
    logic             last;
    logic [CNT_W-1:0] cnt;
    logic             fired;
    logic             dom;
    logic             rec;
  } cantmf_filt_type;

  cantmf_filt_type s_q, s_d;

  always_comb begin
    s_d     = s_q;
    s_d.dom = 1'b0;
    s_d.rec = 1'b0;
    if (!enable_i) begin
      s_d.cnt   = CNT_ZERO;
      s_d.fired = 1'b0;
      s_d.last  = LVL_REC;
    end else if (bus_level_i != s_q.last) begin
      s_d.last  = bus_level_i;
      s_d.cnt   = CNT_ZERO;
      s_d.fired = 1'b0;
    end else if (!s_q.fired) begin
      s_d.cnt = s_q.cnt + CNT_ONE;
      // A state counts as filtered only after strictly more than the filter time
      if (s_q.cnt >= CNT_W'(FILTER_CYCLES)) begin
        s_d.fired = 1'b1;
        s_d.dom   = (s_q.last == LVL_DOM);
        s_d.rec   = (s_q.last == LVL_REC);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '{last: 1'b1, cnt: '0, fired: 1'b0, dom: 1'b0, rec: 1'b0};
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  assign filt_dom_o = s_q.dom;
  assign filt_rec_o = s_q.rec;
endmodule
`default_nettype wire

// ---- design/cantmf_buf.sv ----
// Two-entry buffer carrying the receive level to the controller side
`timescale 1ns/100ps
`default_nettype none
module cantmf_buf #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             clk_en_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  import cantmf_pkg::*;

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               rd;
    logic [PW-1:0]               wr;
    logic [PW:0]                 cnt;
    logic [WIDTH-1:0]            dout;
  } cantmf_buf_type;

  cantmf_buf_type s_q, s_d;
  logic push, pop;

  assign in_ready_o  = (s_q.cnt != (PW+1)'(DEPTH));
  assign out_valid_o = (s_q.cnt != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = s_q.dout;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data_i;
      s_d.wr          = (s_q.wr == PW'(DEPTH-1)) ? '0 : s_q.wr + PW'(1);
    end
    if (pop) begin
      s_d.rd = (s_q.rd == PW'(DEPTH-1)) ? '0 : s_q.rd + PW'(1);
    end
    s_d.cnt  = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    // Head word registered so the data output comes from a flip-flop
    s_d.dout = (s_d.cnt == '0) ? s_q.dout : s_d.mem[s_d.rd];
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '{mem: '1, rd: '0, wr: '0, cnt: '0, dout: '1};
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// ---- verification/cantmf_top_assertions.sv ----
// Concurrent checks on the transceiver control block ports
`timescale 1ns/100ps
`default_nettype none
module cantmf_chk #(
  parameter int DOMTO_CYCLES = 20,
  parameter int MODE_CYCLES = 8
) (
  // Clock and reset
  input wire logic                       ref_clk_i,
  input wire logic                       rstn_i,
  // Pins and monitors
  input wire logic                       txd_i,
  input wire logic                       txd_float_i,
  input wire logic                       standby_select_i,
  input wire logic                       standby_select_float_i,
  input wire logic                       main_supply_undervoltage_i,
  input wire logic                       io_supply_undervoltage_i,
  input wire logic                       thermal_shutdown_i,
  // Outputs watched
  input wire logic                       rxd_o,
  input wire logic                       rxd_oe_o,
  input wire logic                       rxd_valid_o,
  input wire logic                       rxd_ready_i,
  input wire logic                       drv_enable_o,
  input wire logic                       bias_mid_o,
  input wire logic                       bias_gnd_o,
  input wire logic                       rx_main_en_o,
  input wire cantmf_pkg::cantmf_mode_type mode_o,
  input wire logic                       dominant_timeout_o
);
  import cantmf_pkg::*;
  // Counters assume clk_en_i held high; frozen cycles would skew them
  logic uv_any;
  logic sel_hi;
  int   low_q;
  int   dly_q;
  assign uv_any = main_supply_undervoltage_i | io_supply_undervoltage_i;
  assign sel_hi = standby_select_i | standby_select_float_i;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_q <= 0;
      dly_q <= 0;
    end else begin
      low_q <= (mode_o == MODE_NORMAL && !txd_i && !txd_float_i) ?
               ((low_q > DOMTO_CYCLES + 2) ? low_q : low_q + 1) : 0;
      dly_q <= (mode_o == MODE_DELAY) ? dly_q + 1 : 0;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence dly_exit_s;
    $past(mode_o) == MODE_DELAY && !$past(main_supply_undervoltage_i)
      ##0 (mode_o == MODE_NORMAL || mode_o == MODE_STANDBY);
  endsequence
  drv_mode_a: assert property (drv_enable_o
    |-> mode_o == MODE_NORMAL && !dominant_timeout_o)
    else $error("driver enabled outside normal mode");
  domto_fault_a: assert property (dominant_timeout_o && mode_o == MODE_NORMAL
    |-> !drv_enable_o && rx_main_en_o && bias_mid_o) else $error("timeout fault outputs wrong");
  domto_late_a: assert property (low_q == DOMTO_CYCLES + 2 |-> dominant_timeout_o)
    else $error("timeout fault missing");
  domto_early_a: assert property ($rose(dominant_timeout_o) |-> low_q >= DOMTO_CYCLES - 1)
    else $error("timeout fault too early");
  domto_clear_a: assert property (dominant_timeout_o && mode_o == MODE_NORMAL && !uv_any
    && (txd_i || txd_float_i) |=> !dominant_timeout_o) else $error("timeout fault not cleared");
  hot_off_a: assert property (thermal_shutdown_i && mode_o == MODE_NORMAL
    && !uv_any && !sel_hi |=> !drv_enable_o && bias_mid_o && rx_main_en_o)
    else $error("thermal outputs wrong");
  uv_prot_a: assert property (io_supply_undervoltage_i
    |=> mode_o == MODE_PROTECT && !drv_enable_o && !bias_mid_o) else $error("no protect state");
  uv_stby_a: assert property (main_supply_undervoltage_i && !io_supply_undervoltage_i
    && sel_hi |=> mode_o == MODE_STANDBY && bias_gnd_o)
    else $error("no standby under main undervoltage");
  uv_hold_a: assert property (main_supply_undervoltage_i && !io_supply_undervoltage_i
    && !sel_hi |=> mode_o == MODE_PROTECT && !drv_enable_o)
    else $error("no protect with select low");
  dly_exit_a: assert property (dly_exit_s |-> dly_q == MODE_CYCLES)
    else $error("mode delay length wrong");
  buf_hold_a: assert property (rxd_valid_o && !rxd_ready_i
    |=> $stable(rxd_o) && $stable(rxd_oe_o)) else $error("stalled receive word changed");
endmodule
bind cantmf_top cantmf_chk #(.DOMTO_CYCLES(DOMTO_CYCLES), .MODE_CYCLES(MODE_CYCLES)) u_chk (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .txd_i(txd_i), .txd_float_i(txd_float_i),
  .standby_select_i(standby_select_i), .standby_select_float_i(standby_select_float_i),
  .main_supply_undervoltage_i(main_supply_undervoltage_i),
  .io_supply_undervoltage_i(io_supply_undervoltage_i), .thermal_shutdown_i(thermal_shutdown_i),
  .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .rxd_valid_o(rxd_valid_o), .rxd_ready_i(rxd_ready_i),
  .drv_enable_o(drv_enable_o), .bias_mid_o(bias_mid_o), .bias_gnd_o(bias_gnd_o),
  .rx_main_en_o(rx_main_en_o), .mode_o(mode_o), .dominant_timeout_o(dominant_timeout_o));
`default_nettype wire

// ---- verification/cantmf_ctrl_model.sv ----
// Controller-side model: drives transmit and standby pins, drains receive words
`timescale 1ns/100ps
`default_nettype none
module cantmf_ctrl_model (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  // Bench commands
  input  wire logic tx_level_i,
  input  wire logic sel_i,
  input  wire logic stall_i,
  input  wire logic auto_wake_i,
  // Device pins
  output logic      txd_o,
  output logic      standby_select_o,
  output logic      rxd_ready_o,
  input  wire logic rxd_i,
  input  wire logic rxd_oe_i,
  input  wire logic rxd_valid_i,
  // Observed state
  output logic      rx_word_o,
  output logic      woke_o
);
  logic line_lvl;
  // Dominant is held past the timeout only when the bench asks for it
  assign txd_o = tx_level_i;
  assign rxd_ready_o = !stall_i;
  // A released line has no pull, so it shows the inverse of its last value
  assign line_lvl = rxd_oe_i ? rxd_i : !rx_word_o;
  // Wake is answered by pulling standby select low
  assign standby_select_o = sel_i && !(woke_o && auto_wake_i);
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_word_o <= 1'b1;
      woke_o    <= 1'b0;
    end else begin
      if (rxd_valid_i && rxd_ready_o) begin
        rx_word_o <= line_lvl;
      end
      woke_o <= sel_i && (woke_o || (rxd_valid_i && rxd_ready_o && rxd_oe_i && !rxd_i));
    end
  end
endmodule
`default_nettype wire

// ---- verification/cantmf_top_tb.sv ----
// Testbench for the transceiver mode and fault control block
`timescale 1ns/100ps
`default_nettype none
module cantmf_top_tb;
  import cantmf_pkg::*;
  localparam int DOMTO = 20;
  localparam int MDC = 8;
  localparam int WFC = 3;
  localparam int WTO = 60;
  logic ref_clk, rstn, tx, tx_fl, sel, sel_fl, uv_main, uv_io, hot, bus, lp_bus, stall, awake;
  logic txd, sel_pin, ready, rxd, rxd_oe, rxd_valid, drv_dom, drv_en, b_mid, b_gnd, rx_main, rx_lp;
  logic domto, wake_seen, rx_word, woke, ce;
  cantmf_mode_type mode;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  cantmf_top #(.DOMTO_CYCLES(DOMTO), .MODE_CYCLES(MDC), .WFLT_CYCLES(WFC),
    .WTO_CYCLES(WTO)) u_dut (
    .ref_clk_i(ref_clk), .rstn_i(rstn), .clk_en_i(ce), .txd_i(txd), .txd_float_i(tx_fl),
    .standby_select_i(sel_pin), .standby_select_float_i(sel_fl),
    .main_supply_undervoltage_i(uv_main),
    .io_supply_undervoltage_i(uv_io), .thermal_shutdown_i(hot), .bus_dominant_i(bus),
    .lp_bus_dominant_i(lp_bus), .rxd_o(rxd), .rxd_oe_o(rxd_oe), .rxd_valid_o(rxd_valid),
    .rxd_ready_i(ready), .drv_dominant_o(drv_dom), .drv_enable_o(drv_en), .bias_mid_o(b_mid),
    .bias_gnd_o(b_gnd), .rx_main_en_o(rx_main), .rx_lp_en_o(rx_lp), .mode_o(mode),
    .dominant_timeout_o(domto), .wake_seen_o(wake_seen));
  cantmf_ctrl_model u_ctrl (
    .ref_clk_i(ref_clk), .rstn_i(rstn), .tx_level_i(tx), .sel_i(sel), .stall_i(stall),
    .auto_wake_i(awake), .txd_o(txd), .standby_select_o(sel_pin), .rxd_ready_o(ready), .rxd_i(rxd),
    .rxd_oe_i(rxd_oe), .rxd_valid_i(rxd_valid), .rx_word_o(rx_word), .woke_o(woke));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic pins(input logic t, input logic s, input logic b);
    tx = t;
    sel = s;
    bus = b;
  endtask
  task automatic lp_hold(input logic lvl, input int n);
    lp_bus = lvl;
    step(n);
  endtask
  task automatic finish_test;
    $display("Counts: %0d checks, %0d mismatches", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Ceiling well above the roughly 350 cycles the tests take
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    rstn = 1'b0;
    pins(1'b1, 1'b0, 1'b0);
    {tx_fl, sel_fl, uv_main, uv_io, hot, lp_bus, stall, awake} = 8'h00;
    ce = 1'b1;
    step(6);
    check(mode, MODE_PROTECT, "reset mode");
    rstn = 1'b1;
    step(2);
    check(mode, MODE_DELAY, "startup delay");
    step(MDC + 2);
    check(mode, MODE_NORMAL, "normal mode");
    check(drv_en, 1'b1, "driver enabled");
    $display("test startup done");
    pins(1'b0, 1'b0, 1'b1);
    step(4);
    check(drv_dom, 1'b1, "dominant drive");
    check({rxd_oe, rxd}, 2'b10, "rxd dominant");
    stall = 1'b1;
    pins(1'b1, 1'b0, 1'b0);
    step(6);
    check({rxd_valid, rxd}, 2'b10, "stalled rxd");
    stall = 1'b0;
    step(4);
    check({rxd_oe, rxd, drv_dom}, 3'b110, "rxd recessive");
    $display("test echo done");
    pins(1'b0, 1'b0, 1'b1);
    step(DOMTO - 4);
    pins(1'b1, 1'b0, 1'b1);
    step(1);
    pins(1'b0, 1'b0, 1'b1);
    step(DOMTO - 4);
    check(domto, 1'b0, "timeout restarted");
    step(8);
    check({domto, drv_en}, 2'b10, "timeout fault");
    check({rxd, rx_main, b_mid}, 3'b011, "rx during fault");
    bus = 1'b0;
    step(4);
    check(rxd, 1'b1, "rx follows bus");
    pins(1'b1, 1'b0, 1'b0);
    step(2);
    check({domto, drv_en}, 2'b01, "timeout cleared");
    $display("test timeout done");
    pins(1'b0, 1'b0, 1'b1);
    hot = 1'b1;
    step(3);
    check({drv_en, drv_dom}, 2'b00, "thermal driver off");
    check({b_mid, rxd}, 2'b10, "thermal receive");
    hot = 1'b0;
    step(3);
    check({drv_en, drv_dom}, 2'b11, "thermal restored");
    pins(1'b1, 1'b0, 1'b0);
    tx_fl = 1'b1;
    tx = 1'b0;
    step(DOMTO + 5);
    check({domto, drv_dom}, 2'b00, "floating txd");
    tx_fl = 1'b0;
    tx = 1'b1;
    sel_fl = 1'b1;
    step(3);
    check(mode, MODE_STANDBY, "floating select");
    sel_fl = 1'b0;
    step(MDC + 4);
    $display("test thermal and float done");
    pins(1'b1, 1'b1, 1'b0);
    step(3);
    check(mode, MODE_STANDBY, "standby mode");
    check({drv_en, rx_lp}, 2'b01, "standby receivers");
    lp_hold(1'b1, WFC + 3);
    check(rxd, 1'b1, "rxd high before pattern");
    lp_hold(1'b0, WTO + 10);
    lp_hold(1'b1, WFC + 3);
    lp_hold(1'b0, WTO + 10);
    check(woke, 1'b0, "late pattern ignored");
    awake = 1'b1;
    lp_hold(1'b1, WFC + 3);
    lp_hold(1'b0, WFC + 3);
    // Wake shows on the receive pin one edge after recognition, the model sees it one later
    lp_hold(1'b1, WFC + 5);
    check({woke, wake_seen}, 2'b10, "wake signalled");
    lp_hold(1'b0, MDC + 6);
    check(mode, MODE_NORMAL, "woken to normal");
    pins(1'b1, 1'b0, 1'b0);
    awake = 1'b0;
    $display("test wake done");
    uv_io = 1'b1;
    step(4);
    check({mode, rxd_oe}, {MODE_PROTECT, 1'b0}, "io undervoltage");
    uv_io = 1'b0;
    uv_main = 1'b1;
    step(4);
    check({mode, rxd_oe, rxd}, {MODE_PROTECT, 2'b11}, "main uv select low");
    sel = 1'b1;
    step(4);
    check({mode, b_gnd}, {MODE_STANDBY, 1'b1}, "main uv select high");
    sel = 1'b0;
    hot = 1'b1;
    step(3);
    check({mode, drv_en}, {MODE_PROTECT, 1'b0}, "uv over thermal");
    uv_main = 1'b0;
    hot = 1'b0;
    step(2);
    check(mode, MODE_DELAY, "delay entered");
    step(MDC - 3);
    check(mode, MODE_DELAY, "delay held");
    step(4);
    check(mode, MODE_NORMAL, "delay expired");
    $display("test undervoltage done");
    ce = 1'b0;
    sel = 1'b1;
    step(4);
    check(mode, MODE_NORMAL, "frozen by enable");
    ce = 1'b1;
    step(2);
    check(mode, MODE_STANDBY, "enable resumed");
    $display("test clock enable done");
    finish_test();
  end
endmodule
`default_nettype wire
